// ### design/tsc_pkg.sv
package tsc_pkg;

	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam int ADDR_W = 10;
	localparam logic [7:0] IDX_RUN_CTRL = 8'h0E;
	localparam logic [7:0] IDX_T0_MODE = 8'h0F;
	localparam logic [7:0] IDX_RELOAD_HI = 8'h10;
	localparam logic [7:0] IDX_RELOAD_LO = 8'h11;
	localparam logic [7:0] IDX_COUNT_HI = 8'h12;
	localparam logic [7:0] IDX_COUNT_LO = 8'h13;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h21;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int RUN_LSB = 4;
	localparam int STOP_RX_BIT = 7;
	localparam int START_LSB = 4;
	localparam int AUTO_BIT = 3;
	localparam int CLKSEL_LSB = 0;
	localparam logic [7:0] MODE_WR_MASK = 8'hBB;
	localparam int IRQ_UNDERFLOW_BIT = 0;
	localparam int IRQ_RX_STOP_BIT = 1;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [3:0] RUN_RST = 4'h0;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [15:0] RELOAD_RST = 16'h0000;
	localparam logic [15:0] COUNT_RST = 16'h0000;
	localparam logic [1:0] IRQ_RST = 2'h0;

	// ----------------------------------------------------------------
	// bus answers
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// timing: counting clock and its divided tick
	// ----------------------------------------------------------------
	localparam int SYS_CLK_HZ = 13_560_000;
	localparam int DIV_CLK_HZ = 211_875;
	localparam int DIV_RATIO = SYS_CLK_HZ / DIV_CLK_HZ;
	localparam int DIV_W = $clog2(DIV_RATIO);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV_RATIO - 1);

	typedef enum logic [1:0] {
		START_NONE,
		START_AFTER_TX,
		START_LFO_HOLD,
		START_LFO_WRAP
	} tsc_start_e;

	typedef enum logic [1:0] {
		CLK_SYS,
		CLK_DIV,
		CLK_T2_UNDERFLOW,
		CLK_T1_UNDERFLOW
	} tsc_clksel_e;

	function automatic logic [7:0] tsc_reg_index(input logic [ADDR_W-1:0] addr);
		tsc_reg_index = addr[ADDR_W-1:2];
	endfunction

endpackage

// ### design/tsc_prescaler.sv
`timescale 1ns/1ps
module tsc_prescaler
	import tsc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	// divided tick
	output logic tick
);

	logic [DIV_W-1:0] div_reg;
	logic [DIV_W-1:0] div_next;
	logic tick_reg;

	// free running so the tick phase never depends on start time
	assign div_next = (div_reg == DIV_LAST) ? '0 : DIV_W'(div_reg + 1'b1);
	assign tick = tick_reg;

	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			div_reg <= '0;
			tick_reg <= 1'b0;
		end
		else if (ce)
		begin
			div_reg <= div_next;
			tick_reg <= (div_reg == DIV_LAST);
		end

endmodule

// ### design/tsc_sync.sv
`timescale 1ns/1ps
module tsc_sync
	import tsc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	// pin side
	input wire logic pin_in,
	// clean level
	output logic level
);

	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	logic level_reg;

	assign level = level_reg;

	// a change counts only once stages two and three agree
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			level_reg <= 1'b0;
		end
		else if (ce)
		begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg)
				level_reg <= s3_reg;
		end

endmodule

// ### design/tsc_timer_section.sv
// Notes on behaviour
// - run bits change only where mask bit set
// - all ones starts all; F0 changes nothing
// - bits 7..4 show and steer timer running
// - mode: stop-rx 7, start 5:4, restart 3, clk 1:0
// - stop-rx set: stop after first four bits
// - stop-rx ignored in oscillator trimming modes
// - start 00 manual; 01 starts after transmit
// - trimming modes start/stop on oscillator rising edges
// - restart set: reload at zero, keep counting; start 10 holds at zero
// - restart clear: stop at zero, clear running; start 10 holds at zero
// - underflow sets the timer interrupt flag
// - clock 00 system clock, 01 divided clock
// - clock 10 timer two, 11 timer one underflow
// - start loads counter from reload bytes
`timescale 1ns/1ps
module tsc_timer_section
	import tsc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	// axi4-lite write address
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	// axi4-lite write data
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// axi4-lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// axi4-lite read address
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	// axi4-lite read data
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// frame events from the transceiver
	input wire logic tx_frame_done,
	input wire logic rx_first_bits,
	// low_freq_oscillator pin
	input wire logic low_freq_oscillator,
	// neighbour timer underflows
	input wire logic timer_one_underflow,
	input wire logic timer_two_underflow,
	// timer state
	output logic timer_three_active,
	output logic timer_two_active,
	output logic timer_one_active,
	output logic timer_zero_active,
	output logic timer_zero_underflow,
	// interrupt
	output logic irq
);

	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------
	logic aw_held_reg;
	logic w_held_reg;
	logic [ADDR_W-1:0] awaddr_reg;
	logic [7:0] wdata_reg;
	logic wstrb0_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;

	logic wr_fire;
	logic ar_fire;
	logic [7:0] wr_idx;
	logic [7:0] rd_idx;
	logic wr_mapped;
	logic rd_mapped;
	logic [7:0] rd_byte;

	function automatic logic idx_mapped(input logic [7:0] idx);
		idx_mapped = (idx >= IDX_RUN_CTRL && idx <= IDX_COUNT_LO) ||
			idx == IDX_IRQ_STATUS || idx == IDX_IRQ_MASK;
	endfunction

	assign s_axi_awready = ce && !aw_held_reg && !bvalid_reg;
	assign s_axi_wready = ce && !w_held_reg && !bvalid_reg;
	assign s_axi_arready = ce && !rvalid_reg;
	// frozen responses must not complete a handshake
	assign s_axi_bvalid = ce && bvalid_reg;
	assign s_axi_rvalid = ce && rvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	assign wr_fire = ce && aw_held_reg && w_held_reg && !bvalid_reg;
	assign ar_fire = s_axi_arvalid && s_axi_arready;
	assign wr_idx = tsc_reg_index(awaddr_reg);
	assign rd_idx = tsc_reg_index(s_axi_araddr);
	assign wr_mapped = idx_mapped(wr_idx);
	assign rd_mapped = idx_mapped(rd_idx);

	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= 8'h00;
			wstrb0_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
		end
		else if (ce)
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_reg <= 1'b1;
				wdata_reg <= s_axi_wdata[7:0];
				wstrb0_reg <= s_axi_wstrb[0];
			end
			if (wr_fire)
			begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bvalid_reg && s_axi_bready)
				bvalid_reg <= 1'b0;
		end

	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= RESP_OKAY;
		end
		else if (ce)
		begin
			if (ar_fire)
			begin
				rvalid_reg <= 1'b1;
				rdata_reg <= {24'h00_0000, rd_byte};
				rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
			end
			else if (rvalid_reg && s_axi_rready)
				rvalid_reg <= 1'b0;
		end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [3:1] run_hi_reg;
	logic [7:0] mode_reg;
	logic [15:0] reload_reg;
	logic [15:0] count_reg;
	logic [15:0] count_next;
	logic run0_reg;
	logic run0_next;
	logic [1:0] irq_status_reg;
	logic [1:0] irq_mask_reg;
	logic [1:0] irq_set;
	logic uf_reg;

	logic wr_en;
	logic wr_run;
	logic sw_t0;
	logic stop_rx;
	logic auto_restart;
	tsc_start_e start_mode;
	tsc_clksel_e clk_sel;

	assign wr_en = wr_fire && wstrb0_reg;
	assign wr_run = wr_en && wr_idx == IDX_RUN_CTRL;
	assign sw_t0 = wr_run && wdata_reg[0];
	assign stop_rx = mode_reg[STOP_RX_BIT];
	assign auto_restart = mode_reg[AUTO_BIT];
	assign start_mode = tsc_start_e'(mode_reg[START_LSB+1:START_LSB]);
	assign clk_sel = tsc_clksel_e'(mode_reg[CLKSEL_LSB+1:CLKSEL_LSB]);

	// mask bits are strobes and always read back as zero
	assign rd_byte =
		(rd_idx == IDX_RUN_CTRL) ? {run_hi_reg, run0_reg, 4'h0} :
		(rd_idx == IDX_T0_MODE) ? mode_reg :
		(rd_idx == IDX_RELOAD_HI) ? reload_reg[15:8] :
		(rd_idx == IDX_RELOAD_LO) ? reload_reg[7:0] :
		(rd_idx == IDX_COUNT_HI) ? count_reg[15:8] :
		(rd_idx == IDX_COUNT_LO) ? count_reg[7:0] :
		(rd_idx == IDX_IRQ_STATUS) ? {6'h00, irq_status_reg} :
		(rd_idx == IDX_IRQ_MASK) ? {6'h00, irq_mask_reg} : 8'h00;

	// timers three..one only keep their running bit here
	genvar gi;
	generate
		for (gi = 1; gi < 4; gi++)
		begin : g_run
			always_ff @(posedge clk or negedge arst_n)
				if (!arst_n)
					run_hi_reg[gi] <= RUN_RST[gi];
				else if (ce && wr_run && wdata_reg[gi])
					run_hi_reg[gi] <= wdata_reg[RUN_LSB+gi];
		end
	endgenerate

	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			mode_reg <= MODE_RST;
			reload_reg <= RELOAD_RST;
			irq_mask_reg <= IRQ_RST;
		end
		else if (ce && wr_en)
		begin
			if (wr_idx == IDX_T0_MODE)
				mode_reg <= wdata_reg & MODE_WR_MASK;
			if (wr_idx == IDX_RELOAD_HI)
				reload_reg[15:8] <= wdata_reg;
			if (wr_idx == IDX_RELOAD_LO)
				reload_reg[7:0] <= wdata_reg;
			if (wr_idx == IDX_IRQ_MASK)
				irq_mask_reg <= wdata_reg[1:0];
		end

	// ----------------------------------------------------------------
	// timer zero
	// ----------------------------------------------------------------
	logic div_tick;
	logic lfo_level;
	logic lfo_prev_reg;
	logic lfo_rise;
	logic lfo_mode;
	logic hw_start;
	logic rx_stop;
	logic lfo_stop;
	logic tick;
	logic at_zero;
	logic uf_event;

	tsc_prescaler u_prescaler (
		.clk(clk),
		.arst_n(arst_n),
		.ce(ce),
		.tick(div_tick)
	);

	tsc_sync u_lfo_sync (
		.clk(clk),
		.arst_n(arst_n),
		.ce(ce),
		.pin_in(low_freq_oscillator),
		.level(lfo_level)
	);

	assign lfo_rise = lfo_level && !lfo_prev_reg;
	assign lfo_mode = start_mode == START_LFO_HOLD || start_mode == START_LFO_WRAP;
	assign hw_start = !run0_reg && ((start_mode == START_AFTER_TX && tx_frame_done) ||
		(lfo_mode && lfo_rise));
	assign rx_stop = run0_reg && stop_rx && !lfo_mode && rx_first_bits;
	assign lfo_stop = run0_reg && lfo_mode && lfo_rise;
	assign tick = run0_reg && (
		(clk_sel == CLK_SYS) ||
		(clk_sel == CLK_DIV && div_tick) ||
		(clk_sel == CLK_T2_UNDERFLOW && timer_two_underflow) ||
		(clk_sel == CLK_T1_UNDERFLOW && timer_one_underflow));
	assign at_zero = count_reg == 16'h0000;
	// hold-type trimming parks at zero without underflowing
	assign uf_event = ce && !sw_t0 && !rx_stop && !lfo_stop && tick && at_zero &&
		start_mode != START_LFO_HOLD;

	always_comb
	begin
		run0_next = run0_reg;
		count_next = count_reg;
		if (sw_t0)
		begin
			run0_next = wdata_reg[RUN_LSB];
			if (wdata_reg[RUN_LSB])
				count_next = reload_reg;
		end
		else if (rx_stop || lfo_stop)
			run0_next = 1'b0;
		else if (hw_start)
		begin
			run0_next = 1'b1;
			count_next = reload_reg;
		end
		else if (tick)
		begin
			if (!at_zero)
				count_next = 16'(count_reg - 16'h0001);
			else if (start_mode == START_LFO_HOLD)
				count_next = count_reg;
			else if (auto_restart)
				count_next = reload_reg;
			else
				run0_next = 1'b0;
		end
	end

	assign irq_set[IRQ_UNDERFLOW_BIT] = uf_event;
	assign irq_set[IRQ_RX_STOP_BIT] = ce && !sw_t0 && rx_stop;

	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			run0_reg <= RUN_RST[0];
			count_reg <= COUNT_RST;
			lfo_prev_reg <= 1'b0;
			uf_reg <= 1'b0;
			irq_status_reg <= IRQ_RST;
		end
		else if (ce)
		begin
			run0_reg <= run0_next;
			count_reg <= count_next;
			lfo_prev_reg <= lfo_level;
			uf_reg <= uf_event;
			// a new event wins over a clear in the same cycle
			irq_status_reg <= (irq_status_reg &
				~((wr_en && wr_idx == IDX_IRQ_STATUS) ? wdata_reg[1:0] : 2'h0)) | irq_set;
		end

	assign timer_three_active = run_hi_reg[3];
	assign timer_two_active = run_hi_reg[2];
	assign timer_one_active = run_hi_reg[1];
	assign timer_zero_active = run0_reg;
	assign timer_zero_underflow = uf_reg;
	assign irq = |(irq_status_reg & irq_mask_reg);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	property p_mask_keeps;
		wr_run && !wdata_reg[1] |=> $stable(timer_one_active);
	endproperty
	a_mask_keeps: assert property (p_mask_keeps) else $error("unmasked run bit changed");

	property p_all_start;
		wr_run && wdata_reg == 8'hFF |=> timer_three_active && timer_two_active &&
			timer_one_active && timer_zero_active;
	endproperty
	a_all_start: assert property (p_all_start) else $error("all-ones write did not start");

	property p_f0_hold;
		wr_run && wdata_reg == 8'hF0 && !tick && !rx_stop && !lfo_stop && !hw_start
			|=> $stable({run_hi_reg, run0_reg});
	endproperty
	a_f0_hold: assert property (p_f0_hold) else $error("F0 write changed run bits");

	property p_rx_stop;
		ce && run0_reg && stop_rx && !lfo_mode && rx_first_bits && !sw_t0
			|=> !timer_zero_active ##0 irq_status_reg[IRQ_RX_STOP_BIT];
	endproperty
	a_rx_stop: assert property (p_rx_stop) else $error("timer did not stop on receive");

	property p_rx_ignored;
		ce && run0_reg && lfo_mode && rx_first_bits && !sw_t0 && !lfo_rise &&
			!(tick && at_zero && start_mode == START_LFO_WRAP && !auto_restart) |=> timer_zero_active;
	endproperty
	a_rx_ignored: assert property (p_rx_ignored) else $error("trimming stopped on receive");

	property p_tx_start;
		ce && !run0_reg && start_mode == START_AFTER_TX && tx_frame_done && !sw_t0
			|=> timer_zero_active && count_reg == $past(reload_reg);
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("no start after transmit");

	property p_restart;
		uf_event && auto_restart |=> timer_zero_active && count_reg == $past(reload_reg);
	endproperty
	a_restart: assert property (p_restart) else $error("no reload at underflow");

	property p_stop_zero;
		uf_event && !auto_restart |=> !timer_zero_active ##0 timer_zero_underflow ##1
			!timer_zero_underflow;
	endproperty
	a_stop_zero: assert property (p_stop_zero) else $error("timer kept running at zero");

	property p_flag;
		uf_event |=> irq_status_reg[IRQ_UNDERFLOW_BIT] ##0 (!irq_mask_reg[IRQ_UNDERFLOW_BIT] || irq);
	endproperty
	a_flag: assert property (p_flag) else $error("underflow flag not set");

	property p_sys_dec;
		ce && run0_reg && clk_sel == CLK_SYS && !at_zero && !sw_t0 && !rx_stop && !lfo_stop
			|=> count_reg == 16'($past(count_reg) - 16'h0001);
	endproperty
	a_sys_dec: assert property (p_sys_dec) else $error("no decrement on system clock");

	property p_cascade_hold;
		ce && run0_reg && clk_sel == CLK_T2_UNDERFLOW && !timer_two_underflow && !sw_t0
			&& !rx_stop && !lfo_stop |=> $stable(count_reg);
	endproperty
	a_cascade_hold: assert property (p_cascade_hold) else $error("count moved without tick");

	c_restart: cover property (uf_event && auto_restart);
	c_rx_stop: cover property (rx_stop && ce);
	c_lfo_cycle: cover property (hw_start && lfo_mode ##[1:1000] lfo_stop);
	c_irq: cover property (irq);

endmodule

// ### sim/tsc_timer_section_tb.sv
`timescale 1ns/1ps
module tsc_timer_section_tb
	import tsc_pkg::*;
;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic clk, arst_n, ce;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic tx_done, rx_bits, osc, t1_uf, t2_uf;
	logic act3, act2, act1, act0, uf0, irq;
	int error_cnt = 0;
	int samples_checked = 0;
	int uf_cnt = 0;
	int cyc, base;

	tsc_timer_section uut (.clk(clk), .arst_n(arst_n), .ce(ce),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .tx_frame_done(tx_done),
		.rx_first_bits(rx_bits), .low_freq_oscillator(osc),
		.timer_one_underflow(t1_uf), .timer_two_underflow(t2_uf),
		.timer_three_active(act3), .timer_two_active(act2), .timer_one_active(act1),
		.timer_zero_active(act0), .timer_zero_underflow(uf0), .irq(irq));

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	always @(posedge clk)
		if (uf0 === 1'b1)
			uf_cnt++;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic test_done();
		if (error_cnt == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			error_cnt++;
		end
	endtask

	task automatic hang(input string nm);
		$display("CHECK FAILED %s expected answer seen timeout", nm);
		error_cnt++;
		test_done();
	endtask

	// one write; address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
		int n;
		bit a_ok, w_ok;
		n = 0;
		a_ok = 0;
		w_ok = 0;
		awaddr <= {idx, 2'b00};
		wdata <= {24'h00_0000, d};
		wstrb <= 4'h1;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(a_ok && w_ok))
		begin
			@(posedge clk);
			if (!a_ok && awready === 1'b1)
			begin
				a_ok = 1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready === 1'b1)
			begin
				w_ok = 1;
				wvalid <= 1'b0;
			end
			if (++n > 50)
				hang("write handshake");
		end
		do
		begin
			@(posedge clk);
			if (++n > 100)
				hang("write response");
		end
		while (bvalid !== 1'b1);
		chk("bresp", {30'h0, er}, {30'h0, bresp});
	endtask

	task automatic rd(input logic [7:0] idx, input logic [31:0] e, input string nm,
		input logic [1:0] er = RESP_OKAY);
		int n;
		n = 0;
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (++n > 50)
				hang("read address");
		end
		while (arready !== 1'b1);
		arvalid <= 1'b0;
		do
		begin
			@(posedge clk);
			if (++n > 100)
				hang("read data");
		end
		while (rvalid !== 1'b1);
		chk("rresp", {30'h0, er}, {30'h0, rresp});
		chk(nm, e, rdata);
	endtask

	task automatic wait_act(input logic lvl, input int bound, output int c);
		c = 0;
		while (act0 !== lvl)
		begin
			@(posedge clk);
			if (++c > bound)
				hang("timer zero running state");
		end
	endtask

	task automatic pulse(input int which);
		case (which)
			0: tx_done <= 1'b1;
			1: rx_bits <= 1'b1;
			2: t1_uf <= 1'b1;
			default: t2_uf <= 1'b1;
		endcase
		@(posedge clk);
		{tx_done, rx_bits, t1_uf, t2_uf} <= 4'h0;
		repeat (2) @(posedge clk);
	endtask

	task automatic osc_rise();
		osc <= 1'b0;
		repeat (8) @(posedge clk);
		osc <= 1'b1;
		repeat (8) @(posedge clk);
	endtask

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial
	begin
		arst_n = 1'b0;
		ce = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = '0;
		araddr = '0;
		wdata = 32'h0000_0000;
		wstrb = 4'h0;
		{tx_done, rx_bits, osc, t1_uf, t2_uf} = 5'h00;
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 4; i++)
			rd(8'(IDX_RUN_CTRL + i), 32'h0000_0000, "reset value");
		rd(IDX_IRQ_STATUS, 32'h0000_0000, "status reset");
		rd(IDX_IRQ_MASK, 32'h0000_0000, "mask reset");
		wr(IDX_RUN_CTRL, 8'hFF);
		chk("actives all", 32'h0000_000F, {28'h0, act3, act2, act1, act0});
		// reload is zero, so timer zero runs out one tick after the start
		wr(IDX_RUN_CTRL, 8'hF0);
		rd(IDX_RUN_CTRL, 32'h0000_00E0, "run after F0");
		wr(IDX_RUN_CTRL, 8'h0A);
		rd(IDX_RUN_CTRL, 32'h0000_0040, "run masked clear");
		chk("actives masked", 32'h0000_0004, {28'h0, act3, act2, act1, act0});
		wr(IDX_RUN_CTRL, 8'hA5);
		rd(IDX_RUN_CTRL, 32'h0000_0000, "run mixed masks");
		wr(IDX_RUN_CTRL, 8'h02);
		wr(8'h30, 8'h55, RESP_SLVERR);
		rd(8'h30, 32'h0000_0000, "unmapped", RESP_SLVERR);
		wr(IDX_T0_MODE, 8'hFF);
		rd(IDX_T0_MODE, 32'h0000_00BB, "mode reserved bits");
		// one-shot on the system clock
		wr(IDX_T0_MODE, 8'h00);
		wr(IDX_RELOAD_LO, 8'h03);
		base = uf_cnt;
		wr(IDX_RUN_CTRL, 8'h11);
		wait_act(1'b0, 20, cyc);
		repeat (2) @(posedge clk);
		chk("one-shot underflows", 32'd1, uf_cnt - base);
		rd(IDX_COUNT_LO, 32'h0000_0000, "count at zero");
		rd(IDX_IRQ_STATUS, 32'h0000_0001, "underflow flag");
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(IDX_IRQ_MASK, 8'h01);
		chk("irq unmasked", 32'h1, {31'h0, irq});
		wr(IDX_IRQ_STATUS, 8'h01);
		rd(IDX_IRQ_STATUS, 32'h0000_0000, "flag cleared");
		chk("irq cleared", 32'h0, {31'h0, irq});
		// auto reload: reload 2 gives a period of three ticks
		wr(IDX_T0_MODE, 8'h08);
		wr(IDX_RELOAD_LO, 8'h02);
		wr(IDX_RUN_CTRL, 8'h11);
		base = uf_cnt;
		repeat (30) @(posedge clk);
		chk("restart running", 32'h1, {31'h0, act0});
		chk("restart period", 32'h1, {31'h0, (uf_cnt - base) inside {[9:11]}});
		wr(IDX_RUN_CTRL, 8'h01);
		chk("stopped by mask", 32'h0, {31'h0, act0});
		// divided clock: two ticks of a 64-cycle divider
		wr(IDX_T0_MODE, 8'h01);
		wr(IDX_RELOAD_LO, 8'h01);
		wr(IDX_RUN_CTRL, 8'h11);
		wait_act(1'b0, 200, cyc);
		chk("divided tick time", 32'h1, {31'h0, cyc inside {[60:135]}});
		// frame-driven start and early-receive stop
		wr(IDX_RELOAD_HI, 8'hFF);
		wr(IDX_T0_MODE, 8'h00);
		pulse(0);
		chk("no auto start", 32'h0, {31'h0, act0});
		wr(IDX_T0_MODE, 8'h10);
		pulse(0);
		chk("start after tx", 32'h1, {31'h0, act0});
		pulse(1);
		chk("no stop-rx clear", 32'h1, {31'h0, act0});
		wr(IDX_RUN_CTRL, 8'h01);
		wr(IDX_T0_MODE, 8'h90);
		pulse(0);
		pulse(1);
		chk("stopped on rx", 32'h0, {31'h0, act0});
		// underflow flag is still set from the reload runs
		rd(IDX_IRQ_STATUS, 32'h0000_0003, "rx stop event");
		// trimming: start and stop on oscillator rises, stop-rx ignored
		wr(IDX_T0_MODE, 8'hA0);
		osc_rise();
		wait_act(1'b1, 10, cyc);
		pulse(1);
		chk("trim ignores rx", 32'h1, {31'h0, act0});
		osc_rise();
		wait_act(1'b0, 10, cyc);
		// cascade and reload taken only at start; no reception runs here
		wr(IDX_RELOAD_HI, 8'h12);
		wr(IDX_RELOAD_LO, 8'h34);
		wr(IDX_T0_MODE, 8'h02);
		wr(IDX_RUN_CTRL, 8'h11);
		rd(IDX_COUNT_HI, 32'h0000_0012, "count hi loaded");
		wr(IDX_RELOAD_LO, 8'h05);
		pulse(2);
		rd(IDX_COUNT_LO, 32'h0000_0034, "other underflow ignored");
		pulse(3);
		rd(IDX_COUNT_LO, 32'h0000_0033, "timer two tick");
		wr(IDX_T0_MODE, 8'h03);
		pulse(3);
		pulse(2);
		rd(IDX_COUNT_LO, 32'h0000_0032, "timer one tick");
		wr(IDX_RUN_CTRL, 8'h01);
		wr(IDX_RUN_CTRL, 8'h11);
		rd(IDX_COUNT_LO, 32'h0000_0005, "new reload at start");
		// clock enable low: bus blocked, count frozen; two enabled ticks before the freeze
		wr(IDX_T0_MODE, 8'h00);
		@(posedge clk);
		ce <= 1'b0;
		repeat (4) @(posedge clk);
		chk("frozen awready", 32'h0, {31'h0, awready});
		chk("frozen running", 32'h1, {31'h0, act0});
		ce <= 1'b1;
		rd(IDX_COUNT_LO, 32'h0000_0003, "count frozen");
		test_done();
	end
endmodule
